/* design/write_guard_unit.sv */
// Purpose: Write guard between the bus bridge and a guarded module
// Assumes: Requester waits for ack_o; module answers with one ack pulse
// Notes:   One lock bit per byte of the lower 6 KB of module space
//
// What this block does
// - Lock bytes readable always, supervisor-only writes
// - Write enable one lets lock bit change
// - Lock bit m of n guards byte 4n+m
// - Set lock bit blocks writes to byte
// - Mirror write updates register, sets lock bits
// - Hard lock is sticky until reset
// - Hard lock freezes every lock bit
// - Without user access, user writes error out
// - With user access, module rules alone apply
// - User access never affects own registers
// - Each byte has fixed protection size
// - Locked byte readable, writes refused always
// - Unprotected lock bit always reads zero
// - Reserved area accesses go to module
// - Lower module space passes straight through
// - Write touching any locked byte fully blocked
// - Mirror at 0x2000 plus X reaches X
// - Mirror reads leave lock bits alone
// - Global config register at 0x3FFC
`timescale 1ns/1ns
`default_nettype none

module write_guard_unit #(
	// Size code of bytes 0..3 of every guarded word
	parameter logic [7:0]  GRAN_WORD  = 8'hFF,
	// Bytes at or above this module address are unprotected
	parameter logic [12:0] PROT_LIMIT = 13'h1800
) (
	// Clock and reset
	input  wire  logic                      clk_sys_i,
	input  wire  logic                      nrst_i,
	// Request from the bus bridge
	input  wire  logic                      req_valid_i,
	input  wire  write_guard_pkg::bus_req_t req_i,
	// Answer to the bus bridge
	output logic                            ack_o,
	output logic                            err_o,
	output logic [31:0]                     rdata_o,
	// Request to the guarded module
	output write_guard_pkg::mod_req_t       mod_req_o,
	// Answer from the guarded module
	input  wire  logic                      mod_ack_i,
	input  wire  logic                      mod_err_i,
	input  wire  logic [31:0]               mod_rdata_i
);
	import write_guard_pkg::*;

	// ************************************************************
	// Functions
	// ************************************************************
	// Size code of one module byte
	function automatic logic [1:0] gran_of(input logic [12:0] a);
		if (a < PROT_LIMIT && a < PROT_SPACE) begin
			gran_of = GRAN_WORD[{a[1:0], 1'b0} +: 2];
		end else begin
			gran_of = GRAN_NONE;
		end
	endfunction

	// Size codes of the four bytes guarded by one lock register
	function automatic logic [7:0] lane_gran(input logic [10:0] n);
		lane_gran = {gran_of({n, 2'h3}), gran_of({n, 2'h2}),
		             gran_of({n, 2'h1}), gran_of({n, 2'h0})};
	endfunction

	// Bytes sharing one protection unit with byte m
	function automatic logic [3:0] grp_mask(input logic [1:0] code,
	                                        input int m);
		if (code == GRAN_32) begin
			grp_mask = 4'hF;
		end else if (code == GRAN_16) begin
			grp_mask = (m < 2) ? 4'h3 : 4'hC;
		end else begin
			grp_mask = 4'(1 << m);
		end
	endfunction

	// Lock nibble to lock byte read layout
	function automatic logic [7:0] lock_byte(input logic [3:0] l);
		lock_byte = {4'h0, l[0], l[1], l[2], l[3]};
	endfunction

	// ************************************************************
	// State
	// ************************************************************
	logic [3:0]      lock_mem [0:SOFT_LOCK_BYTE_REGISTER_COUNT-1];
	logic            hard_lock;
	logic            user_access_allowed;
	guard_state_t    state;
	logic            pend_mirror;
	logic [10:0]     pend_idx;
	logic [3:0]      pend_set;

	// ************************************************************
	// Address decode
	// ************************************************************
	wire logic [13:0] a          = req_i.addr;
	wire logic        take       = req_valid_i && (state == ST_IDLE);
	wire logic        in_area1   = a < RSVD_BASE;
	wire logic        in_rsvd    = !in_area1 && a < MIRROR_BASE;
	wire logic        in_mirror  = a >= MIRROR_BASE && a < SOFT_LOCK_BYTE_REGISTER_BASE;
	wire logic        in_soft_lock_byte_register    = a >= SOFT_LOCK_BYTE_REGISTER_BASE && a < SOFT_LOCK_BYTE_REGISTER_TOP;
	wire logic        in_gcr     = a[13:2] == GCR_OFFSET[13:2];
	wire logic        to_module  = in_area1 || in_rsvd || in_mirror;
	wire logic        unmapped   = !to_module && !in_soft_lock_byte_register && !in_gcr;
	wire logic        is_write   = req_i.wr && (req_i.be != 4'h0);

	// Mirror drops the area bit to reach the same register
	wire logic [12:0] mod_addr   = a[12:0];
	wire logic [10:0] word_idx   = mod_addr[12:2];
	wire logic        word_prot  = mod_addr < PROT_SPACE;
	wire logic [3:0]  word_lock  = word_prot ? lock_mem[word_idx] : 4'h0;

	// ************************************************************
	// Access checks
	// ************************************************************
	// Any locked byte in the write refuses the whole word
	wire logic lock_hit   = is_write && |(req_i.be & word_lock);
	wire logic user_block = is_write && !req_i.sup
	                        && !user_access_allowed;
	wire logic mirror_hl  = is_write && in_mirror && hard_lock;
	wire logic fwd_err    = lock_hit || user_block || mirror_hl;
	// Own registers ignore user access: supervisor writes only
	wire logic own_wr_bad = is_write && !req_i.sup;
	wire logic soft_lock_byte_register_err   = own_wr_bad || (is_write && hard_lock);
	wire logic local_err  = unmapped
	                        || (to_module && fwd_err)
	                        || (in_soft_lock_byte_register && soft_lock_byte_register_err)
	                        || (in_gcr && own_wr_bad);
	wire logic forward    = take && to_module && !fwd_err;

	// ************************************************************
	// Mirror lock set mask
	// ************************************************************
	// Lock bits of every protectable unit touched by the write
	logic [3:0] mirror_set;
	always_comb begin
		logic [1:0] code;
		mirror_set = 4'h0;
		code       = GRAN_NONE;
		for (int m = 0; m < 4; m++) begin
			code = gran_of({word_idx, 2'(m)});
			mirror_set[m] = (code != GRAN_NONE)
			                && |(req_i.be & grp_mask(code, m));
		end
	end

	// ************************************************************
	// Direct lock register lanes
	// ************************************************************
	logic [10:0] lane_idx  [0:3];
	logic [3:0]  lane_new  [0:3];
	logic [31:0] soft_lock_byte_register_rd;
	wire logic   soft_lock_byte_register_wr   = take && in_soft_lock_byte_register && is_write && !soft_lock_byte_register_err;

	genvar j;
	generate
		for (j = 0; j < 4; j++) begin : g_lane
			// Four lock registers share one bus word
			assign lane_idx[j] = {a[10:2], 2'(j)};
			assign soft_lock_byte_register_rd[8*j +: 8] = lock_byte(lock_mem[lane_idx[j]]);
			slb_lane_update i_slb_lane_update (
				.gran_i (lane_gran(lane_idx[j])),
				.byte_i (req_i.wdata[8*j +: 8]),
				.old_i  (lock_mem[lane_idx[j]]),
				.new_o  (lane_new[j])
			);
		end
	endgenerate

	// ************************************************************
	// Local read data and config writes
	// ************************************************************
	wire logic [31:0] gcr_rd = {30'h0, user_access_allowed, hard_lock};
	wire logic [31:0] loc_rd = (in_soft_lock_byte_register && !req_i.wr) ? soft_lock_byte_register_rd
	                         : (in_gcr && !req_i.wr) ? gcr_rd
	                         : 32'h0;
	wire logic gcr_wr = take && in_gcr && is_write && !own_wr_bad
	                    && req_i.be[0];
	// Set only; a written zero never clears it
	wire logic next_hard_lock = hard_lock
	                            || (gcr_wr && req_i.wdata[HLB_POS]);
	wire logic next_uaa = gcr_wr ? req_i.wdata[UAA_POS]
	                             : user_access_allowed;

	// Lock set lands as the module completes the write
	wire logic mirror_done = (state == ST_WAIT) && mod_ack_i && pend_mirror
	                         && !mod_err_i && !hard_lock;

	// ************************************************************
	// Lock bit storage
	// ************************************************************
	// Reads never touch this array; only the two write paths do
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			for (int n = 0; n < SOFT_LOCK_BYTE_REGISTER_COUNT; n++) begin
				lock_mem[n] <= LOCK_RESET;
			end
		end else if (soft_lock_byte_register_wr) begin
			for (int k = 0; k < 4; k++) begin
				if (req_i.be[k]) begin
					lock_mem[lane_idx[k]] <= lane_new[k];
				end
			end
		end else if (mirror_done) begin
			lock_mem[pend_idx] <= lock_mem[pend_idx] | pend_set;
		end
	end

	// ************************************************************
	// Global configuration
	// ************************************************************
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hard_lock           <= HLB_RESET;
			user_access_allowed <= UAA_RESET;
		end else begin
			hard_lock           <= next_hard_lock;
			user_access_allowed <= next_uaa;
		end
	end

	// ************************************************************
	// Transfer sequencing
	// ************************************************************
	wire logic mod_done = (state == ST_WAIT) && mod_ack_i;
	guard_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (forward) begin
					next_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (mod_ack_i) begin
					next_state = ST_IDLE;
				end
			end
		endcase
	end

	// Outgoing module request, held until the module acknowledges
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state       <= ST_IDLE;
			mod_req_o   <= '0;
			pend_mirror <= 1'b0;
			pend_idx    <= '0;
			pend_set    <= 4'h0;
		end else begin
			state <= next_state;
			if (forward) begin
				mod_req_o   <= {1'b1, mod_addr, req_i.wr, req_i.be,
				                req_i.wdata, req_i.sup};
				pend_mirror <= in_mirror && is_write && word_prot;
				pend_idx    <= word_idx;
				pend_set    <= mirror_set;
			end else if (mod_done) begin
				mod_req_o.valid <= 1'b0;
				pend_mirror     <= 1'b0;
			end
		end
	end

	// Answer to the bridge: local at once, forwarded on module ack
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_o   <= 1'b0;
			err_o   <= 1'b0;
			rdata_o <= 32'h0;
		end else if (mod_done) begin
			ack_o   <= 1'b1;
			err_o   <= mod_err_i;
			rdata_o <= mod_rdata_i;
		end else if (take && !forward) begin
			ack_o   <= 1'b1;
			err_o   <= local_err;
			rdata_o <= local_err ? 32'h0 : loc_rd;
		end else begin
			ack_o   <= 1'b0;
			err_o   <= 1'b0;
			rdata_o <= 32'h0;
		end
	end

endmodule // write_guard_unit

`default_nettype wire

/* include/write_guard_pkg.sv */
// Purpose: Shared constants and types of the register write guard
// Assumes: 16 KB window, 32-bit data, byte enables, one clock
// Notes:   Offsets are byte addresses within the guarded window
package write_guard_pkg;

	// ************************************************************
	// Address map
	// ************************************************************
	localparam int              ADDR_W       = 14;
	localparam int              MOD_ADDR_W   = 13;
	localparam logic [13:0]     RSVD_BASE    = 14'h1800;
	localparam logic [13:0]     MIRROR_BASE  = 14'h2000;
	localparam logic [13:0]     SOFT_LOCK_BYTE_REGISTER_BASE    = 14'h3800;
	localparam logic [13:0]     SOFT_LOCK_BYTE_REGISTER_TOP     = 14'h3E00;
	localparam logic [13:0]     GCR_OFFSET   = 14'h3FFC;
	localparam logic [12:0]     PROT_SPACE   = 13'h1800;
	localparam int              SOFT_LOCK_BYTE_REGISTER_COUNT   = 1536;
	localparam int              SOFT_LOCK_BYTE_REGISTER_IDX_W   = 11;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int              HLB_POS      = 0;
	localparam int              UAA_POS      = 1;
	localparam logic [3:0]      LOCK_RESET   = 4'h0;
	localparam logic            HLB_RESET    = 1'b0;
	localparam logic            UAA_RESET    = 1'b0;

	// Protection size codes, two bits per module byte
	localparam logic [1:0]      GRAN_NONE    = 2'h0;
	localparam logic [1:0]      GRAN_8       = 2'h1;
	localparam logic [1:0]      GRAN_16      = 2'h2;
	localparam logic [1:0]      GRAN_32      = 2'h3;

	// ************************************************************
	// Types
	// ************************************************************
	typedef struct packed {
		logic [13:0] addr;
		logic        wr;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic        sup;
	} bus_req_t;

	typedef struct packed {
		logic        valid;
		logic [12:0] addr;
		logic        wr;
		logic [3:0]  be;
		logic [31:0] wdata;
		logic        sup;
	} mod_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [31:0] rdata;
	} bus_rsp_t;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} guard_state_t;

endpackage

/* design/slb_lane_update.sv */
// Purpose: New lock nibble for one lock byte register on a direct write
// Assumes: Byte layout WE0..WE3 in bits 7..4, SLB0..SLB3 in bits 3..0
// Notes:   Pure combinational; gran_i holds the size code of each byte
`timescale 1ns/1ns
`default_nettype none

module slb_lane_update (
	// Protection size codes of the four guarded bytes
	input  wire  logic [7:0] gran_i,
	// Written byte and present lock bits
	input  wire  logic [7:0] byte_i,
	input  wire  logic [3:0] old_i,
	// Resulting lock bits
	output logic       [3:0] new_o
);
	import write_guard_pkg::*;

	// ************************************************************
	// Per-bit update with size mirroring
	// ************************************************************
	// A wider size takes enable and value from its lowest bit only
	always_comb begin
		logic [1:0] code;
		int         base;
		new_o = old_i;
		code  = GRAN_NONE;
		base  = 0;
		for (int m = 0; m < 4; m++) begin
			code = gran_i[2*m +: 2];
			if (code == GRAN_32) begin
				base = 0;
			end else if (code == GRAN_16) begin
				base = m & 2;
			end else begin
				base = m;
			end
			if (code == GRAN_NONE) begin
				new_o[m] = 1'b0;
			end else if (byte_i[7-base]) begin
				new_o[m] = byte_i[3-base];
			end else begin
				new_o[m] = old_i[m];
			end
		end
	end

endmodule // slb_lane_update

`default_nettype wire

/* verification/write_guard_monitor.sv */
// Purpose: Port-level checks of the write guard
// Assumes: Bound to write_guard_unit, one clock domain
// Notes:   Unit counts as idle while no forwarded access is open
`timescale 1ns/1ns
`default_nettype none

module write_guard_monitor (
	// Clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      nrst_i,
	// Bridge side
	input  wire logic                      req_valid_i,
	input  wire write_guard_pkg::bus_req_t req_i,
	input  wire logic                      ack_o,
	input  wire logic                      err_o,
	input  wire logic [31:0]               rdata_o,
	// Module side
	input  wire write_guard_pkg::mod_req_t mod_req_o,
	input  wire logic                      mod_ack_i,
	input  wire logic                      mod_err_i,
	input  wire logic [31:0]               mod_rdata_i
);
	import write_guard_pkg::*;

	// ********
	// Request decode
	// ********
	// A write with no byte enable is treated as a read
	wire tk   = req_valid_i && !mod_req_o.valid;
	wire w_op = req_i.wr && (req_i.be != 4'h0);
	wire a_lo = !req_i.addr[13];
	wire a_mi = req_i.addr[13] && (req_i.addr < SOFT_LOCK_BYTE_REGISTER_BASE);
	wire a_lk = (req_i.addr >= SOFT_LOCK_BYTE_REGISTER_BASE) && (req_i.addr < SOFT_LOCK_BYTE_REGISTER_TOP);

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);

	a_ack_has_cause: assert property (ack_o |->
		$past(tk) || $past(mod_ack_i && mod_req_o.valid))
		else $error("answer without a cause");
	a_err_only_ack: assert property (err_o |-> ack_o)
		else $error("error outside an answer");
	a_mod_hold: assert property (mod_req_o.valid && !mod_ack_i
		|=> mod_req_o.valid && $stable(mod_req_o))
		else $error("module request changed while open");
	a_mod_pass: assert property (mod_req_o.valid && mod_ack_i
		&& !mod_req_o.wr |=> ack_o && (err_o == $past(mod_err_i))
		&& (err_o || rdata_o == $past(mod_rdata_i)))
		else $error("module answer not passed on");
	a_mirror_maps: assert property (tk && !w_op && a_mi
		|=> mod_req_o.valid && mod_req_o.addr == $past(req_i.addr[12:0]))
		else $error("mirror read not mapped down");
	a_low_passes: assert property (tk && !w_op && a_lo
		|=> mod_req_o.valid && mod_req_o.addr == $past(req_i.addr[12:0]))
		else $error("module read not passed through");
	a_lock_rd_fmt: assert property (tk && !w_op && a_lk
		|=> ack_o && !err_o && !mod_req_o.valid
		&& (rdata_o & 32'hF0F0F0F0) == 32'h0)
		else $error("lock read badly answered");
	a_user_lock_wr: assert property (tk && w_op && !req_i.sup
		&& req_i.addr >= SOFT_LOCK_BYTE_REGISTER_BASE |=> ack_o && err_o && !mod_req_o.valid)
		else $error("user write to own registers accepted");
	a_cfg_rd: assert property (tk && !w_op
		&& req_i.addr == GCR_OFFSET |=> ack_o && !err_o
		&& rdata_o[31:2] == 30'h0)
		else $error("config read badly answered");
endmodule // write_guard_monitor

bind write_guard_unit write_guard_monitor i_write_guard_monitor (
	.clk_sys_i   (clk_sys_i),
	.nrst_i      (nrst_i),
	.req_valid_i (req_valid_i),
	.req_i       (req_i),
	.ack_o       (ack_o),
	.err_o       (err_o),
	.rdata_o     (rdata_o),
	.mod_req_o   (mod_req_o),
	.mod_ack_i   (mod_ack_i),
	.mod_err_i   (mod_err_i),
	.mod_rdata_i (mod_rdata_i)
);
`default_nettype wire

/* verification/mod_partner.sv */
// Purpose: Behavioural guarded module behind the write guard
// Assumes: 64 words of storage, answer after a set delay
// Notes:   Read data toggles outside the answer cycle
`timescale 1ns/1ns
`default_nettype none

module mod_partner (
	// Clock and reset
	input  wire logic                      clk_sys_i,
	input  wire logic                      nrst_i,
	// Request from the guard and test controls
	input  wire write_guard_pkg::mod_req_t req_i,
	input  wire logic [3:0]                dly_i,
	input  wire logic                      fail_i,
	// Answer to the guard
	output logic                           ack_o,
	output logic                           err_o,
	output logic [31:0]                    rdata_o
);
	import write_guard_pkg::*;
	logic [31:0] mem [64];
	logic [3:0]  wait_cnt;
	wire         fire = req_i.valid && !ack_o && (wait_cnt >= dly_i);
	wire  [5:0]  idx  = req_i.addr[7:2];

	// One answer pulse per request, never a stale data word
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			ack_o <= 1'h0;
			err_o <= 1'h0;
			rdata_o <= 32'h0;
			wait_cnt <= 4'h0;
		end else begin
			ack_o <= fire;
			err_o <= fire && fail_i;
			rdata_o <= fire ? mem[idx] : ~rdata_o;
			wait_cnt <= (req_i.valid && !fire) ? wait_cnt + 4'h1 : 4'h0;
		end
	end

	// A failed write leaves storage untouched
	always_ff @(posedge clk_sys_i) begin
		for (int k = 0; k < 4; k++) begin
			if (fire && req_i.wr && !fail_i && req_i.be[k]) begin
				mem[idx][8*k +: 8] <= req_i.wdata[8*k +: 8];
			end
		end
	end
endmodule // mod_partner
`default_nettype wire

/* verification/test_write_guard_unit.sv */
// Purpose: Self-checking bench of the write guard
// Assumes: Lanes 0,1 16-bit, lane 2 unprotected, lane 3 8-bit
// Notes:   Lock byte: enables in bits 7..4, lock bits in 3..0
`timescale 1ns/1ns
`default_nettype none

module test_write_guard_unit;
	import write_guard_pkg::*;
	logic        clk_sys_i = 1'h0;
	logic        nrst_i = 1'h0;
	logic        req_valid_i = 1'h0;
	bus_req_t    req_i = '0;
	logic        ack_o;
	logic        err_o;
	logic [31:0] rdata_o;
	mod_req_t    mod_req_o;
	logic        mod_ack_i;
	logic        mod_err_i;
	logic [31:0] mod_rdata_i;
	logic [3:0]  dly = 4'h0;
	logic        merr = 1'h0;
	logic [31:0] e;
	logic [31:0] r;
	int          failures = 0;
	int          total_checks = 0;
	int          cycles = 0;

	write_guard_unit #(.GRAN_WORD(8'h4A), .PROT_LIMIT(13'h1800))
	i_write_guard_unit (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.req_valid_i(req_valid_i), .req_i(req_i), .ack_o(ack_o),
		.err_o(err_o), .rdata_o(rdata_o), .mod_req_o(mod_req_o),
		.mod_ack_i(mod_ack_i), .mod_err_i(mod_err_i),
		.mod_rdata_i(mod_rdata_i));
	mod_partner i_mod_partner (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.req_i(mod_req_o), .dly_i(dly), .fail_i(merr),
		.ack_o(mod_ack_i), .err_o(mod_err_i), .rdata_o(mod_rdata_i));

	// ********
	// Clock, watchdog, shared tasks
	// ********
	always #50 clk_sys_i = ~clk_sys_i;
	// A run still going at cycle 5000 ends as a failure
	always @(posedge clk_sys_i) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures = failures + 1;
			end_of_test();
		end
	end
	task automatic end_of_test;
		if (failures == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		total_checks++;
		if (s !== x) begin
			failures++;
			$display("wrong value at %0t: seen %h not %h", $time, s, x);
		end
	endtask
	// One strobe cycle, then wait for the answer pulse
	task automatic acc(input logic [13:0] a, input logic w,
		input logic [3:0] b, input logic [31:0] d, input logic s);
		int n;
		n = 0;
		@(posedge clk_sys_i);
		req_valid_i <= 1'h1;
		req_i <= '{a, w, b, d, s};
		@(posedge clk_sys_i);
		req_valid_i <= 1'h0;
		@(negedge clk_sys_i);
		while (ack_o !== 1'h1 && n < 40) begin
			@(negedge clk_sys_i);
			n++;
		end
		e = {31'h0, err_o};
		r = rdata_o;
		chk({31'h0, ack_o}, 32'h1);
	endtask
	task automatic wr(input logic [13:0] a, input logic [3:0] b,
		input logic [31:0] d, input logic s, input logic [31:0] x);
		acc(a, 1'h1, b, d, s);
		chk(e, x);
	endtask
	task automatic rd(input logic [13:0] a, input logic s,
		input logic [31:0] x);
		acc(a, 1'h0, 4'hF, 32'h0, s);
		chk(e, 32'h0);
		chk(r, x);
	endtask

	// ********
	// Scenarios
	// ********
	task automatic t_reset;
		rd(14'h3800, 1'h1, 32'h0);
		rd(GCR_OFFSET, 1'h0, 32'h0);
		wr(14'h0010, 4'hF, 32'h0, 1'h0, 32'h1);
		wr(14'h0010, 4'hF, 32'hA1B2C3D4, 1'h1, 32'h0);
		rd(14'h2010, 1'h0, 32'hA1B2C3D4);
		rd(14'h3804, 1'h1, 32'h0);
	endtask
	task automatic t_direct;
		wr(14'h3804, 4'h1, 32'h000000FB, 1'h1, 32'h0);
		rd(14'h3804, 1'h0, 32'h0000000D);
		wr(14'h3804, 4'h1, 32'h00000040, 1'h1, 32'h0);
		rd(14'h3804, 1'h0, 32'h0000000D);
		wr(14'h3804, 4'h1, 32'h00000080, 1'h1, 32'h0);
		rd(14'h3804, 1'h0, 32'h00000001);
		wr(14'h3804, 4'h1, 32'h000000F0, 1'h0, 32'h1);
	endtask
	task automatic t_locked;
		wr(14'h0010, 4'hF, 32'h0, 1'h1, 32'h1);
		wr(14'h0010, 4'h1, 32'h00000055, 1'h1, 32'h0);
		wr(14'h2010, 4'h8, 32'h0, 1'h1, 32'h1);
		rd(14'h0010, 1'h0, 32'hA1B2C355);
	endtask
	task automatic t_mirror;
		wr(14'h2020, 4'hF, 32'h11223344, 1'h1, 32'h0);
		wr(14'h2024, 4'h1, 32'h00000066, 1'h1, 32'h0);
		rd(14'h3808, 1'h0, 32'h00000C0D);
		rd(14'h0020, 1'h0, 32'h11223344);
		wr(14'h0020, 4'h2, 32'h0, 1'h1, 32'h1);
	endtask
	task automatic t_module;
		merr = 1'h1;
		acc(14'h1800, 1'h0, 4'hF, 32'h0, 1'h1);
		chk(e, 32'h1);
		wr(14'h2030, 4'hF, 32'h1, 1'h1, 32'h1);
		merr = 1'h0;
		dly = 4'h6;
		rd(14'h380C, 1'h0, 32'h0);
		rd(14'h0020, 1'h0, 32'h11223344);
		dly = 4'h0;
	endtask
	task automatic t_user;
		wr(GCR_OFFSET, 4'h1, 32'h2, 1'h1, 32'h0);
		rd(GCR_OFFSET, 1'h0, 32'h2);
		wr(14'h0040, 4'hF, 32'h7, 1'h0, 32'h0);
		wr(14'h3810, 4'h1, 32'hF0, 1'h0, 32'h1);
	endtask
	task automatic t_hard;
		wr(GCR_OFFSET, 4'h1, 32'h3, 1'h1, 32'h0);
		wr(GCR_OFFSET, 4'h1, 32'h2, 1'h1, 32'h0);
		rd(GCR_OFFSET, 1'h1, 32'h3);
		wr(14'h3804, 4'h1, 32'hF0, 1'h1, 32'h1);
		rd(14'h3804, 1'h1, 32'h1);
		wr(14'h2044, 4'hF, 32'h0, 1'h1, 32'h1);
		acc(14'h3E00, 1'h0, 4'hF, 32'h0, 1'h1);
		chk(e, 32'h1);
		@(posedge clk_sys_i);
		nrst_i <= 1'h0;
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'h1;
		rd(GCR_OFFSET, 1'h1, 32'h0);
		rd(14'h3804, 1'h1, 32'h0);
	endtask

	// Reset for 20 cycles, then every scenario in turn
	initial begin
		repeat (20) @(posedge clk_sys_i);
		nrst_i <= 1'h1;
		t_reset();
		t_direct();
		t_locked();
		t_mirror();
		t_module();
		t_user();
		t_hard();
		end_of_test();
	end
endmodule // test_write_guard_unit
`default_nettype wire
